// [core/sio_fifo.sv]
// Sixteen-entry FIFO with registered head word and one-entry mode
`timescale 1ns/1ps
`include "sio_regs.svh"

module sio_fifo #(
	parameter int WIDTH = 12
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic push,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic pop,
	input wire logic deep,
	output logic [WIDTH-1:0] headData,
	output logic [4:0] count,
	output logic empty,
	output logic full
);

	logic [WIDTH-1:0] mem [16];
	logic [3:0] wrPtr_reg;
	logic [3:0] rdPtr_reg;
	logic [4:0] count_reg;
	logic [WIDTH-1:0] head_reg;
	logic [3:0] rdPtr_next;
	logic doPush;
	logic doPop;

	assign empty = (count_reg == 5'h00);
	// Holding-register mode reports full at one entry
	assign full = count_reg >= (deep ? `SIO_FIFO_DEPTH : 5'h01);
	assign doPush = push && !full;
	assign doPop = pop && !empty;
	assign rdPtr_next = doPop ? rdPtr_reg + 4'h1 : rdPtr_reg;
	assign count = count_reg;
	assign headData = head_reg;

	always_ff @(posedge mclk)
	begin
		if (doPush)
			mem[wrPtr_reg] <= wrData;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPtr_reg <= 4'h0;
			rdPtr_reg <= 4'h0;
			count_reg <= 5'h00;
			head_reg <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr_reg <= wrPtr_reg + 4'h1;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_reg + {4'h0, doPush} - {4'h0, doPop};
			// Write-through keeps the head valid in the cycle after a push into empty
			if (doPush && wrPtr_reg == rdPtr_next)
				head_reg <= wrData;
			else
				head_reg <= mem[rdPtr_next];
		end
	end

endmodule

// [core/sio_pkg.sv]
// Shared types and parity helper for the serial port
package sio_pkg;

	typedef struct packed {
		logic stickPar;
		logic [1:0] wordLen;
		logic fifoEn;
		logic twoStop;
		logic evenPar;
		logic parEn;
		logic sendBreak;
	} sio_line_t;

	typedef struct packed {
		logic overrun;
		logic brk;
		logic parity;
		logic framing;
		logic [7:0] data;
	} sio_rxent_t;

	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_START = 3'b001,
		SER_DATA = 3'b010,
		SER_PAR = 3'b011,
		SER_STOP = 3'b100
	} sio_ser_t;

	function automatic logic parityBit(input logic [7:0] data, input sio_line_t cfg);
		logic [7:0] m;
		m = data & (8'hFF >> (2'h3 - cfg.wordLen));
		if (cfg.stickPar)
			parityBit = ~cfg.evenPar;
		else
			parityBit = cfg.evenPar ? ^m : ~^m;
	endfunction

endpackage

// [core/sio_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SIO_REGS_SVH
`define SIO_REGS_SVH

`define SIO_OFF_DATA 12'h000
`define SIO_OFF_RSR 12'h004
`define SIO_OFF_FLAG 12'h018
`define SIO_OFF_ILPR 12'h020
`define SIO_OFF_IBRD 12'h024
`define SIO_OFF_FBRD 12'h028
`define SIO_OFF_LCRH 12'h02C
`define SIO_OFF_CTL 12'h030
`define SIO_OFF_IFLS 12'h034
`define SIO_OFF_IMSK 12'h038
`define SIO_OFF_RIS 12'h03C
`define SIO_OFF_MIS 12'h040
`define SIO_OFF_ICR 12'h044

`define SIO_CTL_EN 0
`define SIO_CTL_SIR 1
`define SIO_CTL_SIRLP 2
`define SIO_CTL_LBE 7
`define SIO_CTL_TXE 8
`define SIO_CTL_RXE 9
`define SIO_CTL_RST 10'h300
`define SIO_IFLS_RST 6'h12

`define SIO_EV_RX 4
`define SIO_EV_TX 5
`define SIO_EV_RT 6
`define SIO_EV_FE 7
`define SIO_EV_PE 8
`define SIO_EV_BE 9
`define SIO_EV_OE 10
`define SIO_EV_USED 11'h7F0

`define SIO_FR_BUSY 3
`define SIO_FR_RX_EMPTY_FLAG 4
`define SIO_FR_TX_FULL_FLAG 5
`define SIO_FR_RX_FULL_FLAG 6
`define SIO_FR_TX_EMPTY_FLAG 7

`define SIO_FIFO_DEPTH 5'h10
`define SIO_TICK_LAST 4'hF
`define SIO_START_MID 4'h7
`define SIO_IR_PULSE 4'h3
`define SIO_LP_PULSE 2'h3
`define SIO_RT_TICKS 10'h200
`define SIO_MIN_IDX 3'h4

`endif

// [core/sio_rx.sv]
// Receive shifter: start validation, data, parity and stop sampling
`timescale 1ns/1ps
`include "sio_regs.svh"

module sio_rx (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic baudTick,
	input wire logic rxLine,
	input wire logic rxEnable,
	input wire sio_pkg::sio_line_t lineCfg,
	output logic charDone,
	output sio_pkg::sio_rxent_t charEntry
);

	sio_pkg::sio_ser_t state_reg;
	logic [3:0] tick_reg;
	logic [2:0] idx_reg;
	logic prevLine_reg;
	logic allLow_reg;
	logic [7:0] data_reg;
	logic parErr_reg;
	logic sampleNow;

	assign sampleNow = baudTick && tick_reg == `SIO_TICK_LAST;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= sio_pkg::SER_IDLE;
			tick_reg <= 4'h0;
			idx_reg <= 3'h0;
			prevLine_reg <= 1'b1;
			allLow_reg <= 1'b0;
			data_reg <= 8'h00;
			parErr_reg <= 1'b0;
			charDone <= 1'b0;
			charEntry <= '0;
		end
		else
		begin
			prevLine_reg <= rxLine;
			charDone <= 1'b0;
			if (baudTick && state_reg != sio_pkg::SER_IDLE)
				tick_reg <= tick_reg + 4'h1;
			case (state_reg)
				sio_pkg::SER_IDLE:
				begin
					tick_reg <= 4'h0;
					if (rxEnable && prevLine_reg && !rxLine)
						state_reg <= sio_pkg::SER_START; // [R4]
				end
				sio_pkg::SER_START:
				begin
					if (baudTick && tick_reg == `SIO_START_MID)
					begin
						tick_reg <= 4'h0;
						idx_reg <= 3'h0;
						data_reg <= 8'h00;
						allLow_reg <= 1'b1;
						parErr_reg <= 1'b0;
						// False start drops back to idle with nothing stored
						state_reg <= rxLine ? sio_pkg::SER_IDLE : sio_pkg::SER_DATA; // [R4] [R26]
					end
				end
				sio_pkg::SER_DATA:
				begin
					if (sampleNow)
					begin
						data_reg[idx_reg] <= rxLine; // [R5]
						allLow_reg <= allLow_reg && !rxLine;
						idx_reg <= idx_reg + 3'h1;
						if (idx_reg == `SIO_MIN_IDX + {1'b0, lineCfg.wordLen})
							state_reg <= lineCfg.parEn ? sio_pkg::SER_PAR : sio_pkg::SER_STOP;
					end
				end
				sio_pkg::SER_PAR:
				begin
					if (sampleNow)
					begin
						parErr_reg <= rxLine != sio_pkg::parityBit(data_reg, lineCfg); // [R6]
						allLow_reg <= allLow_reg && !rxLine;
						state_reg <= sio_pkg::SER_STOP;
					end
				end
				sio_pkg::SER_STOP:
				begin
					if (sampleNow)
					begin
						charDone <= 1'b1; // [R7]
						charEntry.overrun <= 1'b0;
						charEntry.brk <= allLow_reg && !rxLine;
						charEntry.parity <= parErr_reg;
						charEntry.framing <= !rxLine; // [R6]
						charEntry.data <= data_reg;
						state_reg <= sio_pkg::SER_IDLE;
					end
				end
				default:
					state_reg <= sio_pkg::SER_IDLE;
			endcase
		end
	end

endmodule

// [core/sio_top.sv]
// Serial port core: registers, FIFOs, transmitter, infrared codec, events
// Function
// R1: Two 16-entry FIFOs, receive entries carry status
// R2: Enabled unit sends frames until FIFO empty
// R3: Busy from FIFO non-empty until stop sent
// R4: Falling edge, confirm start on eighth tick
// R5: Data bits sampled every sixteen ticks
// R6: Check parity, stop must be high
// R7: Store character with its own error flags
// R8: Normal infrared: zero is 3/16 high pulse
// R9: Codec uses serial bits, decoder feeds receiver
// R10: Low-power pulse is three low-power ticks
// R11: Software waits 10 ms before receiving
// R12: Infrared link is half-duplex only
// R13: Data read twelve bits, write eight
// R14: FIFOs start as single holding registers
// R15: Empty, full and overrun flags reported
// R16: Trigger levels eighths, default one half
// R17: All events ORed into one request
// R18: Mask gates request, raw and masked readable
// R19: Clear register clears raw and masked
// R20: Timeout after 32 idle bits, cleared
// R21: Loopback routes transmit into receive
// R22: Software programs divisor, line, then enable
// R23: Sixteen-times tick clocks and samples bits
// R24: Divisor is 16.6 fixed-point value
// R25: Start, data LSB first, parity, stops
// R26: False start returns to idle silently
`timescale 1ns/1ps
`include "sio_regs.svh"

module sio_top (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	input wire logic serialInPin,
	output logic serialOutPin,
	output logic irq
);

	function automatic logic [4:0] levelOf(input logic [2:0] sel);
		case (sel)
			3'h0: levelOf = 5'h02;
			3'h1: levelOf = 5'h04;
			3'h3: levelOf = 5'h0C;
			3'h4: levelOf = 5'h0E;
			default: levelOf = 5'h08;
		endcase
	endfunction

	logic [7:0] lineControl_reg;
	logic [9:0] control_reg;
	logic [15:0] integerDivisor_reg;
	logic [5:0] fractionDivisor_reg;
	logic [15:0] divIntLatch_reg;
	logic [5:0] divFracLatch_reg;
	logic [7:0] lowPowerDiv_reg;
	logic [5:0] fifoLevelSelect_reg;
	logic [10:0] eventMask_reg;
	logic [10:0] rawEvent_reg;
	logic [10:0] rawEvent_next;
	logic [10:0] evtSet;
	logic [10:0] evtClr;
	sio_pkg::sio_line_t lineCfg;
	logic unitEn;
	logic [1:0] rxSync_reg;
	logic [31:0] rdData_next;
	logic txPush;
	logic rxPop;
	logic errClr;

	assign lineCfg = sio_pkg::sio_line_t'(lineControl_reg);
	assign unitEn = control_reg[`SIO_CTL_EN];
	assign txPush = regWrite && regAddr == `SIO_OFF_DATA;
	assign rxPop = regRead && regAddr == `SIO_OFF_DATA;
	assign errClr = regWrite && regAddr == `SIO_OFF_RSR;

	////////////////////////////////////////////////////////////////////////////
	// Software-written registers

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lineControl_reg <= 8'h00;
			control_reg <= `SIO_CTL_RST;
			integerDivisor_reg <= 16'h0000;
			fractionDivisor_reg <= 6'h00;
			divIntLatch_reg <= 16'h0000;
			divFracLatch_reg <= 6'h00;
			lowPowerDiv_reg <= 8'h00;
			fifoLevelSelect_reg <= `SIO_IFLS_RST; // [R16]
			eventMask_reg <= 11'h000;
		end
		else if (regWrite)
		begin
			case (regAddr)
				`SIO_OFF_LCRH:
				begin
					lineControl_reg <= regWrData[7:0]; // [R14]
					// Divisor only takes effect with a line-control write
					divIntLatch_reg <= integerDivisor_reg; // [R24]
					divFracLatch_reg <= fractionDivisor_reg;
				end
				`SIO_OFF_CTL: control_reg <= regWrData[9:0];
				`SIO_OFF_IBRD: integerDivisor_reg <= regWrData[15:0];
				`SIO_OFF_FBRD: fractionDivisor_reg <= regWrData[5:0];
				`SIO_OFF_ILPR: lowPowerDiv_reg <= regWrData[7:0];
				`SIO_OFF_IFLS: fifoLevelSelect_reg <= regWrData[5:0];
				`SIO_OFF_IMSK: eventMask_reg <= regWrData[10:0] & `SIO_EV_USED;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Oversampling tick and low-power infrared tick

	logic [16:0] baudCnt_reg;
	logic [5:0] fracAcc_reg;
	logic baudTick;
	logic [6:0] fracSum;
	logic [7:0] lpCnt_reg;
	logic lpTick;

	assign fracSum = {1'b0, fracAcc_reg} + {1'b0, divFracLatch_reg};

	// Period is N clocks, or N+1 on a fraction-accumulator carry, so the average is N plus frac/64
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			baudCnt_reg <= 17'h00001;
			fracAcc_reg <= 6'h00;
			baudTick <= 1'b0;
		end
		else if (divIntLatch_reg == 16'h0000)
		begin
			baudCnt_reg <= 17'h00001;
			baudTick <= 1'b0;
		end
		else if (baudCnt_reg <= 17'h00001)
		begin
			baudTick <= 1'b1; // [R23]
			fracAcc_reg <= fracSum[5:0];
			baudCnt_reg <= {1'b0, divIntLatch_reg} + {16'h0000, fracSum[6]}; // [R24]
		end
		else
		begin
			baudTick <= 1'b0;
			baudCnt_reg <= baudCnt_reg - 17'h00001;
		end
	end

	// Divider of 0 acts as 256
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lpCnt_reg <= 8'h00;
			lpTick <= 1'b0;
		end
		else
		begin
			lpTick <= lpCnt_reg == 8'h00;
			lpCnt_reg <= (lpCnt_reg == 8'h00) ? lowPowerDiv_reg - 8'h01 : lpCnt_reg - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// FIFOs

	logic [7:0] txHead;
	logic [4:0] txCount;
	logic txEmpty;
	logic txFull;
	logic txPop;
	sio_pkg::sio_rxent_t rxHead;
	sio_pkg::sio_rxent_t rxEntry;
	sio_pkg::sio_rxent_t rxPushEntry;
	logic [4:0] rxCount;
	logic rxEmpty;
	logic rxFull;
	logic rxDone;
	logic rxPush;
	logic overrun;
	logic oePend_reg;

	assign rxPush = rxDone && !rxFull; // [R7]
	assign overrun = rxDone && rxFull;
	assign rxPushEntry = {oePend_reg, rxEntry.brk, rxEntry.parity, rxEntry.framing, rxEntry.data};

	sio_fifo #(.WIDTH(8)) txFifo ( // [R1]
		.mclk(mclk),
		.arst_n(arst_n),
		.push(txPush),
		.wrData(regWrData[7:0]), // [R13]
		.pop(txPop),
		.deep(lineCfg.fifoEn), // [R14]
		.headData(txHead),
		.count(txCount),
		.empty(txEmpty),
		.full(txFull)
	);

	sio_fifo #(.WIDTH(12)) rxFifo ( // [R1]
		.mclk(mclk),
		.arst_n(arst_n),
		.push(rxPush),
		.wrData(rxPushEntry),
		.pop(rxPop),
		.deep(lineCfg.fifoEn), // [R14]
		.headData(rxHead),
		.count(rxCount),
		.empty(rxEmpty),
		.full(rxFull)
	);

	// Overrun flag rides on the next character that gets in
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			oePend_reg <= 1'b0;
		else if (overrun)
			oePend_reg <= 1'b1;
		else if (rxPush)
			oePend_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmitter

	sio_pkg::sio_ser_t txState_reg;
	logic [3:0] txTick_reg;
	logic [2:0] txIdx_reg;
	logic txSecond_reg;
	logic [7:0] txData_reg;
	logic txBit;
	logic txActive;
	logic txBusy;
	logic txStep;

	assign txActive = txState_reg != sio_pkg::SER_IDLE;
	assign txBusy = !txEmpty || txActive; // [R3]
	assign txStep = baudTick && txTick_reg == `SIO_TICK_LAST; // [R23]
	assign txPop = !txActive && unitEn && control_reg[`SIO_CTL_TXE] && !txEmpty; // [R2]

	always_comb
	begin
		case (txState_reg)
			sio_pkg::SER_START: txBit = 1'b0; // [R25]
			sio_pkg::SER_DATA: txBit = txData_reg[txIdx_reg];
			sio_pkg::SER_PAR: txBit = sio_pkg::parityBit(txData_reg, lineCfg);
			default: txBit = 1'b1;
		endcase
		if (lineCfg.sendBreak)
			txBit = 1'b0;
	end

	// A started frame always completes even if the unit is disabled
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			txState_reg <= sio_pkg::SER_IDLE;
			txTick_reg <= 4'h0;
			txIdx_reg <= 3'h0;
			txSecond_reg <= 1'b0;
			txData_reg <= 8'h00;
		end
		else
		begin
			if (baudTick && txActive)
				txTick_reg <= txTick_reg + 4'h1;
			case (txState_reg)
				sio_pkg::SER_IDLE:
				begin
					txTick_reg <= 4'h0;
					if (txPop)
					begin
						txData_reg <= txHead;
						txState_reg <= sio_pkg::SER_START; // [R2]
					end
				end
				sio_pkg::SER_START:
				begin
					txIdx_reg <= 3'h0;
					if (txStep)
						txState_reg <= sio_pkg::SER_DATA;
				end
				sio_pkg::SER_DATA:
				begin
					if (txStep)
					begin
						txIdx_reg <= txIdx_reg + 3'h1; // [R25]
						txSecond_reg <= 1'b0;
						if (txIdx_reg == `SIO_MIN_IDX + {1'b0, lineCfg.wordLen})
							txState_reg <= lineCfg.parEn ? sio_pkg::SER_PAR : sio_pkg::SER_STOP;
					end
				end
				sio_pkg::SER_PAR:
				begin
					if (txStep)
						txState_reg <= sio_pkg::SER_STOP;
				end
				sio_pkg::SER_STOP:
				begin
					if (txStep && lineCfg.twoStop && !txSecond_reg)
						txSecond_reg <= 1'b1;
					else if (txStep)
						txState_reg <= sio_pkg::SER_IDLE; // [R3]
				end
				default:
					txState_reg <= sio_pkg::SER_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Infrared codec, loopback and pin sampling

	logic sirEn;
	logic [1:0] lpPulse_reg;
	logic [3:0] irStretch_reg;
	logic rawRx;
	logic rxLine;
	logic serialOut_next;

	assign sirEn = control_reg[`SIO_CTL_SIR];
	assign rawRx = control_reg[`SIO_CTL_LBE] ? (sirEn ? ~serialOutPin : serialOutPin)
		: rxSync_reg[1]; // [R21]
	// Receiver is deaf while infrared transmit is busy
	assign rxLine = sirEn ? (txBusy || (rawRx && irStretch_reg == 4'h0)) : rawRx; // [R9] [R12]

	always_comb
	begin
		serialOut_next = txBit;
		if (sirEn && control_reg[`SIO_CTL_SIRLP])
			serialOut_next = lpPulse_reg != 2'h0; // [R10]
		else if (sirEn)
			serialOut_next = txActive && !txBit && txTick_reg < `SIO_IR_PULSE; // [R8] [R9]
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxSync_reg <= 2'b11;
			serialOutPin <= 1'b1;
			lpPulse_reg <= 2'h0;
			irStretch_reg <= 4'h0;
		end
		else
		begin
			rxSync_reg <= {rxSync_reg[0], serialInPin};
			serialOutPin <= serialOut_next;
			if (txActive && baudTick && txTick_reg == 4'h0 && !txBit)
				lpPulse_reg <= `SIO_LP_PULSE; // [R10]
			else if (lpTick && lpPulse_reg != 2'h0)
				lpPulse_reg <= lpPulse_reg - 2'h1;
			// Short light pulse is held low for about one bit period
			if (!rawRx)
				irStretch_reg <= `SIO_TICK_LAST; // [R9]
			else if (baudTick && irStretch_reg != 4'h0)
				irStretch_reg <= irStretch_reg - 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver and receive status

	logic oeStick_reg;
	logic [2:0] errSeen_reg;

	sio_rx rxCore (
		.mclk(mclk),
		.arst_n(arst_n),
		.baudTick(baudTick),
		.rxLine(rxLine),
		.rxEnable(unitEn && control_reg[`SIO_CTL_RXE]),
		.lineCfg(lineCfg),
		.charDone(rxDone),
		.charEntry(rxEntry)
	);

	// Overrun shows at once; other errors follow the character last read
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			oeStick_reg <= 1'b0;
			errSeen_reg <= 3'h0;
		end
		else
		begin
			if (overrun)
				oeStick_reg <= 1'b1; // [R15]
			else if (errClr)
				oeStick_reg <= 1'b0;
			if (rxPop && !rxEmpty)
				errSeen_reg <= {rxHead.brk, rxHead.parity, rxHead.framing};
			else if (errClr)
				errSeen_reg <= 3'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Events

	logic txLvl;
	logic rxLvl;
	logic txLvlPrev_reg;
	logic rxLvlPrev_reg;
	logic [9:0] rtCnt_reg;

	assign txLvl = lineCfg.fifoEn ? txCount <= levelOf(fifoLevelSelect_reg[2:0]) : txEmpty;
	assign rxLvl = lineCfg.fifoEn ? rxCount >= levelOf(fifoLevelSelect_reg[5:3]) : !rxEmpty;

	always_comb
	begin
		evtSet = 11'h000;
		evtSet[`SIO_EV_TX] = txLvl && !txLvlPrev_reg; // [R16]
		evtSet[`SIO_EV_RX] = rxLvl && !rxLvlPrev_reg; // [R16]
		evtSet[`SIO_EV_RT] = baudTick && rtCnt_reg == `SIO_RT_TICKS - 10'h001; // [R20]
		evtSet[`SIO_EV_FE] = rxPush && rxEntry.framing;
		evtSet[`SIO_EV_PE] = rxPush && rxEntry.parity;
		evtSet[`SIO_EV_BE] = rxDone && rxEntry.brk;
		evtSet[`SIO_EV_OE] = overrun;
		evtClr = (regWrite && regAddr == `SIO_OFF_ICR) ? regWrData[10:0] : 11'h000; // [R19]
		evtClr[`SIO_EV_RT] = evtClr[`SIO_EV_RT] || rxEmpty; // [R20]
		// A new event wins over a clear in the same cycle
		rawEvent_next = ((rawEvent_reg & ~evtClr) | evtSet) & `SIO_EV_USED;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rawEvent_reg <= 11'h000;
			txLvlPrev_reg <= 1'b0;
			rxLvlPrev_reg <= 1'b0;
			rtCnt_reg <= 10'h000;
			irq <= 1'b0;
		end
		else
		begin
			rawEvent_reg <= rawEvent_next;
			txLvlPrev_reg <= txLvl;
			rxLvlPrev_reg <= rxLvl;
			if (rxEmpty || rxPush)
				rtCnt_reg <= 10'h000;
			else if (baudTick && rtCnt_reg != `SIO_RT_TICKS)
				rtCnt_reg <= rtCnt_reg + 10'h001; // [R20]
			irq <= |(rawEvent_next & eventMask_reg); // [R17] [R18]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe

	always_comb
	begin
		rdData_next = 32'h00000000;
		if (regRead)
		begin
			case (regAddr)
				`SIO_OFF_DATA: rdData_next[11:0] = rxHead; // [R13]
				`SIO_OFF_RSR: rdData_next[3:0] = {oeStick_reg, errSeen_reg};
				`SIO_OFF_FLAG:
				begin
					rdData_next[`SIO_FR_BUSY] = txBusy; // [R3]
					rdData_next[`SIO_FR_RX_EMPTY_FLAG] = rxEmpty; // [R15]
					rdData_next[`SIO_FR_TX_FULL_FLAG] = txFull;
					rdData_next[`SIO_FR_RX_FULL_FLAG] = rxFull;
					rdData_next[`SIO_FR_TX_EMPTY_FLAG] = txEmpty;
				end
				`SIO_OFF_ILPR: rdData_next[7:0] = lowPowerDiv_reg;
				`SIO_OFF_IBRD: rdData_next[15:0] = integerDivisor_reg;
				`SIO_OFF_FBRD: rdData_next[5:0] = fractionDivisor_reg;
				`SIO_OFF_LCRH: rdData_next[7:0] = lineControl_reg;
				`SIO_OFF_CTL: rdData_next[9:0] = control_reg;
				`SIO_OFF_IFLS: rdData_next[5:0] = fifoLevelSelect_reg;
				`SIO_OFF_IMSK: rdData_next[10:0] = eventMask_reg;
				`SIO_OFF_RIS: rdData_next[10:0] = rawEvent_reg; // [R18]
				`SIO_OFF_MIS: rdData_next[10:0] = rawEvent_reg & eventMask_reg; // [R18]
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			regRdData <= 32'h00000000;
		else
			regRdData <= rdData_next;
	end

endmodule

// [test/sio_peer.sv]
// Remote serial peer: drives frames in and decodes bytes sent out
`timescale 1ns/1ps
module sio_peer (
	input wire logic mclk,
	input wire logic lineIn,
	output logic lineOut
);
	logic [7:0] lastByte;
	// Pulled-up line: high whenever no frame is driven
	initial lineOut = 1'b1;
	task automatic frame(input logic [10:0] bits, input int n, input int w);
		for (int i = 0; i < n; i++)
			repeat (w) @(posedge mclk) lineOut <= bits[i];
		@(posedge mclk) lineOut <= 1'b1;
	endtask
	// Sampled on the falling clock, clear of the output update
	always
	begin
		@(negedge lineIn);
		repeat (8) @(negedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (16) @(negedge mclk);
			lastByte[i] = lineIn;
		end
		repeat (16) @(negedge mclk);
	end
endmodule

// [test/sio_properties.sv]
// Bus and flag assertions for the serial port core
`timescale 1ns/1ps
module sio_properties (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdData,
	input wire logic serialInPin,
	input wire logic serialOutPin,
	input wire logic irq
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	wire rdFlag = regRead && regAddr == 12'h018;
	wire rdData = regRead && regAddr == 12'h000;
	wire wrData = regWrite && regAddr == 12'h000;
	a_rd_idle_zero: assert property (!$past(regRead) |-> regRdData == 32'h0)
		else $error("read data not zero");
	a_hole_reads_zero: assert property (regRead && regAddr == 12'h008 |=> !regRdData)
		else $error("unmapped read not zero");
	a_data_width: assert property (rdData |=> regRdData[31:12] == 20'h0)
		else $error("data read too wide");
	a_flag_spare_zero: assert property (rdFlag |=> !regRdData[31:8] && !regRdData[2:0])
		else $error("flag spare bits set");
	a_busy_after_write: assert property (wrData ##1 rdFlag |=> regRdData[3])
		else $error("busy low after write");
	a_tx_empty_flag_after_write: assert property (wrData ##1 rdFlag |=> !regRdData[7])
		else $error("tx empty after write");
	a_mask_off_irq: assert property (regWrite && regAddr == 12'h038 && !regWrData[10:0]
		|-> ##2 !irq)
		else $error("irq with mask clear");
	a_status_clear: assert property (regWrite && regAddr == 12'h004
		##1 regRead && regAddr == 12'h004 |=> regRdData[3:0] == 4'h0)
		else $error("status not cleared");
endmodule
bind sio_top sio_properties chk (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.serialInPin(serialInPin), .serialOutPin(serialOutPin), .irq(irq));

// [test/sio_top_test.sv]
// Self-checking bench for the serial port core
`timescale 1ns/1ps
module sio_top_test;
	localparam int FRAME = 160;
	logic mclk;
	logic arst_n = 1'b0;
	logic [11:0] regAddr = 12'h0;
	logic [31:0] regWrData = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdData;
	logic serialInPin;
	logic serialOutPin;
	logic irq;
	logic [31:0] hiCnt = 32'h0;
	int error_cnt = 0;
	int compares = 0;
	sio_top uut (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.serialInPin(serialInPin), .serialOutPin(serialOutPin), .irq(irq));
	sio_peer peer (.mclk(mclk), .lineIn(serialOutPin), .lineOut(serialInPin));
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("Compares %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Strobe left high so a read may follow with no gap
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		regRead <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what,
		input logic [31:0] m = 32'hFFFFFFFF);
		regAddr <= a;
		regWrite <= 1'b0;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		@(negedge mclk);
		check(what, regRdData & m, exp);
		@(posedge mclk);
	endtask
	task automatic cyc(input int n);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask
	// Run needs about 5300 cycles; generous margin
	initial
	begin
		#400000;
		error_cnt++;
		end_of_test();
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rd(12'h030, 32'h300, "ctl");
		rd(12'h034, 32'h12, "ifls");
		rd(12'h018, 32'h90, "flag");
		rd(12'h008, 32'h0, "hole");
		wr(12'h024, 32'h1);
		wr(12'h028, 32'h0);
		wr(12'h02C, 32'h60);
		wr(12'h000, 32'h11);
		rd(12'h018, 32'h38, "flag 1-deep");
		wr(12'h000, 32'h22);
		wr(12'h030, 32'h301);
		cyc(2 * FRAME);
		check("peer byte", {24'h0, peer.lastByte}, 32'h11);
		rd(12'h018, 32'h90, "flag idle");
		wr(12'h030, 32'h300);
		wr(12'h02C, 32'h70);
		for (int i = 0; i < 15; i++)
			wr(12'h000, 32'h40 + i);
		rd(12'h018, 32'h18, "flag 15");
		wr(12'h000, 32'h4F);
		wr(12'h000, 32'h50);
		rd(12'h018, 32'h38, "flag full");
		wr(12'h044, 32'h20);
		rd(12'h03C, 32'h0, "tx lvl clr", 32'h20);
		wr(12'h030, 32'h301);
		cyc(17 * FRAME);
		check("peer last", {24'h0, peer.lastByte}, 32'h4F);
		rd(12'h018, 32'h90, "flag drained");
		rd(12'h03C, 32'h20, "tx lvl", 32'h20);
		wr(12'h030, 32'h381);
		wr(12'h000, 32'hA6);
		cyc(2 * FRAME);
		rd(12'h000, 32'hA6, "loop data");
		wr(12'h030, 32'h301);
		cyc(1);
		peer.frame(11'h0, 1, 6);
		cyc(FRAME);
		rd(12'h018, 32'h90, "false start");
		peer.frame(11'h14A, 10, 16);
		cyc(20);
		wr(12'h038, 32'h80);
		cyc(3);
		check("irq", {31'h0, irq}, 32'h1);
		rd(12'h040, 32'h80, "mis", 32'h80);
		cyc(600);
		rd(12'h03C, 32'h40, "ris rt", 32'h40);
		rd(12'h000, 32'h1A5, "framing");
		rd(12'h03C, 32'h0, "rt gone", 32'h40);
		wr(12'h044, 32'h7F0);
		rd(12'h03C, 32'h0, "ris fe", 32'h80);
		check("irq off", {31'h0, irq}, 32'h0);
		wr(12'h038, 32'h0);
		wr(12'h030, 32'h300);
		wr(12'h02C, 32'h60);
		wr(12'h030, 32'h301);
		cyc(1);
		// Second character meets a full holding register
		peer.frame(11'h2B4, 10, 16);
		peer.frame(11'h2B4, 10, 16);
		cyc(2);
		rd(12'h004, 32'h8, "rsr oe", 32'h8);
		rd(12'h03C, 32'h400, "ris oe", 32'h400);
		rd(12'h000, 32'h5A, "held char");
		wr(12'h030, 32'h300);
		wr(12'h02C, 32'h76);
		wr(12'h030, 32'h301);
		cyc(1);
		peer.frame(11'h606, 11, 16);
		cyc(20);
		// Overrun mark rides on the next stored character
		rd(12'h000, 32'hA03, "parity");
		wr(12'h004, 32'h0);
		rd(12'h004, 32'h0, "rsr");
		wr(12'h030, 32'h303);
		wr(12'h000, 32'hFF);
		cyc(1);
		repeat (2 * FRAME) @(negedge mclk) hiCnt += serialOutPin;
		check("ir pulses", hiCnt, 32'h6);
		// No infrared receive follows, so no turnaround gap is owed
		cyc(1);
		end_of_test();
	end
endmodule
